// file: fsio_fail_out.sv
// Fail output logic: three active-low indicator outputs and the safe input
// window check. Assumes all inputs synchronous to clk; the status clear
// strobes come from the register logic as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "fsio_params.svh"

module fsio_fail_out #(
  parameter int BLINK_HALF_CYC = `FSIO_BLINK_HALF_CYC,
  parameter int DIM_PERIOD_CYC = `FSIO_DIM_PERIOD_CYC,
  parameter int DIM_ON_CYC     = `FSIO_DIM_ON_CYC,
  parameter int WIN_CYC        = `FSIO_WIN_CYC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Failure sources and operating mode
  input  wire fsio_pkg::fsio_fail_in_s fail_in,
  input  wire logic                  watchdog_fail_flag,
  input  wire logic                  normal_mode,
  // Control bits
  input  wire logic                  watchdog_fail_flag_count_cfg,
  input  wire logic                  safe_input_disable,
  input  wire logic                  clr_fail_out_active,
  input  wire logic                  clr_safe_input_fail,
  // Safe input pin
  input  wire logic                  safe_input_pin,
  // Fail outputs, active low
  output logic                       static_fail_out_n,
  output logic                       blink_fail_out_n,
  output logic                       dim_fail_out_n,
  // Status
  output var fsio_pkg::fsio_status_s device_status_reg
);

  fsio_pkg::fsio_state_e state;
  logic        wd_seen;
  logic        wd_trip;
  logic        clamp;
  logic        cond;
  logic        si_prev;
  logic        si_rise;
  logic        si_edge_seen;
  logic        si_chk;
  logic [31:0] win_cnt;
  logic [31:0] blink_cnt;
  logic [31:0] dim_cnt;
  logic        blink_ph;
  logic        active;
  logic        fo_flag;
  logic        si_flag;
  logic        clamp_flag;

  assign clamp = fail_in.reset_out_asserted & fail_in.reset_out_pin_fb;
  assign wd_trip = fail_in.watchdog_fail_flag_event & (~watchdog_fail_flag_count_cfg | wd_seen);
  assign cond = fail_in.thermal_shutdown_stage2 |
                fail_in.main_supply_rail_short | clamp |
                (watchdog_fail_flag & (state == fsio_pkg::FSIO_ACTIVE));
  assign active = (state == fsio_pkg::FSIO_ACTIVE);
  assign si_rise = safe_input_pin & ~si_prev;
  assign si_chk = normal_mode & ~safe_input_disable;
  // Status word gathered from one flop per flag
  assign device_status_reg = {fo_flag, si_flag, clamp_flag};

  // Watchdog fail count memory; cleared when the watchdog flag drops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wd_seen <= 1'b0;
    end else if (fail_in.watchdog_fail_flag_event) begin
      wd_seen <= 1'b1;
    end else if (!watchdog_fail_flag) begin
      wd_seen <= 1'b0;
    end
  end

  // Fail output controller
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= fsio_pkg::FSIO_IDLE;
    end else begin
      case (state)
        fsio_pkg::FSIO_IDLE: begin
          if (wd_trip || fail_in.thermal_shutdown_stage2 ||
              fail_in.main_supply_rail_short || clamp) begin
            state <= fsio_pkg::FSIO_ACTIVE;
          end
        end
        fsio_pkg::FSIO_ACTIVE: begin
          if (!cond && !fo_flag &&
              !wd_trip) begin
            state <= fsio_pkg::FSIO_IDLE;
          end
        end
        default: state <= fsio_pkg::FSIO_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fo_flag <= 1'b0;
    end else if (wd_trip || cond && !active ||
                 fail_in.thermal_shutdown_stage2 ||
                 fail_in.main_supply_rail_short || clamp) begin
      fo_flag <= 1'b1;
    end else if (clr_fail_out_active) begin
      fo_flag <= 1'b0;
    end
  end

  // Reset clamp status, set wins over clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clamp_flag <= 1'b0;
    end else if (clamp) begin
      clamp_flag <= 1'b1;
    end else if (clr_fail_out_active) begin
      clamp_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      si_prev <= 1'b0;
      win_cnt <= '0;
    end else begin
      si_prev <= safe_input_pin;
      if (!si_chk || si_rise || win_cnt == 32'(WIN_CYC - 1)) begin
        win_cnt <= '0;
      end else begin
        win_cnt <= win_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      si_flag <= 1'b0;
      si_edge_seen <= 1'b0;
    end else begin
      if (si_chk && !si_rise && win_cnt == 32'(WIN_CYC - 1)) begin
        si_flag <= 1'b1;
        si_edge_seen <= 1'b0;
      end else begin
        if (si_rise) begin
          si_edge_seen <= 1'b1;
        end
        if (clr_safe_input_fail && (si_edge_seen || si_rise)) begin
          si_flag <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !active) begin
      blink_cnt <= '0;
      blink_ph  <= 1'b1;
    end else if (blink_cnt == 32'(BLINK_HALF_CYC - 1)) begin
      blink_cnt <= '0;
      blink_ph  <= ~blink_ph;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !(active || si_flag)) begin
      dim_cnt <= '0;
    end else if (dim_cnt == 32'(DIM_PERIOD_CYC - 1)) begin
      dim_cnt <= '0;
    end else begin
      dim_cnt <= dim_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      static_fail_out_n <= 1'b1;
      blink_fail_out_n  <= 1'b1;
      dim_fail_out_n    <= 1'b1;
    end else begin
      static_fail_out_n <= ~(active | si_flag);
      blink_fail_out_n  <= ~(active & blink_ph);
      dim_fail_out_n    <= ~((active | si_flag)
                             & (dim_cnt < 32'(DIM_ON_CYC)));
    end
  end

  // Static output follows the active state one cycle later
  static_low_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(active) |-> !static_fail_out_n)
    else $error("static output not low while active");

  // Thermal failure must reach the outputs within two cycles
  thermal_act_a: assert property (@(posedge clk) disable iff (!nrst)
    fail_in.thermal_shutdown_stage2 |-> ##2 !static_fail_out_n)
    else $error("thermal failure did not activate outputs");

  // Active flag set after a reset clamp
  flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
    clamp |=> fo_flag)
    else $error("active flag not set");

  // Single watchdog fail does not trip when two are configured
  wd_count_a: assert property (@(posedge clk) disable iff (!nrst)
    (watchdog_fail_flag_count_cfg && !wd_seen && fail_in.watchdog_fail_flag_event && !cond &&
     state == fsio_pkg::FSIO_IDLE && !fail_in.thermal_shutdown_stage2 &&
     !fail_in.main_supply_rail_short) |=> !active)
    else $error("tripped on first watchdog fail");

  // Outputs stay on while the flag remains set
  hold_active_a: assert property (@(posedge clk) disable iff (!nrst)
    (active && fo_flag) |=> active)
    else $error("released while flag set");

  // Watchdog flag keeps outputs active
  wd_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (active && watchdog_fail_flag) |=> active)
    else $error("released during watchdog fail");

  // Blink output stands for a half period before toggling
  blink_half_a: assert property (@(posedge clk) disable iff (!nrst)
    (active && blink_cnt == 32'h0 && $past(active)) |=>
      $stable(blink_ph))
    else $error("blink phase changed early");

  // Dimmer on only in the first fifth of the period
  dim_duty_a: assert property (@(posedge clk) disable iff (!nrst)
    (dim_cnt >= 32'(DIM_ON_CYC)) |=> dim_fail_out_n)
    else $error("dimmer on outside its on time");

  // No checking outside normal mode
  si_mode_a: assert property (@(posedge clk) disable iff (!nrst)
    !si_chk |=> win_cnt == 32'h0)
    else $error("window ran outside normal mode");

  // Safe input flag cannot clear without an edge
  si_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    (si_flag && !si_edge_seen && !si_rise)
      |=> si_flag)
    else $error("safe input flag cleared without edge");

endmodule

`default_nettype wire

// file: fsio_params.svh
// Constants for the fail output and safe input block.
// Assumes a 100 MHz clock; included by the design file.
`ifndef FSIO_PARAMS_SVH
`define FSIO_PARAMS_SVH

`define FSIO_CLK_HZ          100000000
// Blink output: 1.25 Hz, half period 400 ms, in microseconds
`define FSIO_BLINK_HALF_US   400000
// Dimmer output: 100 Hz, period 10 ms, on time 2 ms (20 %)
`define FSIO_DIM_PERIOD_US   10000
`define FSIO_DIM_ON_US       2000
// Safe input window time, longest, in microseconds
`define FSIO_WINDOW_US       240
`define FSIO_WINDOW_CYC      ((`FSIO_WINDOW_US * 100) )
// Cycle counts derived from the clock rate (100 cycles per microsecond)
`define FSIO_CYC_PER_US      (`FSIO_CLK_HZ / 1000000)
`define FSIO_BLINK_HALF_CYC  (`FSIO_BLINK_HALF_US * `FSIO_CYC_PER_US)
`define FSIO_DIM_PERIOD_CYC  (`FSIO_DIM_PERIOD_US * `FSIO_CYC_PER_US)
`define FSIO_DIM_ON_CYC      (`FSIO_DIM_ON_US * `FSIO_CYC_PER_US)
`define FSIO_WIN_CYC         (`FSIO_WINDOW_US * `FSIO_CYC_PER_US)
// Reset values
`define FSIO_RST_WD2         1'b0
`define FSIO_RST_SI_DIS      1'b0

`endif

// file: fsio_pkg.sv
// Types for the fail output and safe input block.
// Assumes nothing beyond the params header.
package fsio_pkg;

  // Failure sources feeding the fail outputs
  typedef struct packed {
    logic watchdog_fail_flag_event;
    logic thermal_shutdown_stage2;
    logic main_supply_rail_short;
    logic reset_out_asserted;
    logic reset_out_pin_fb;
  } fsio_fail_in_s;

  // Device status bits
  typedef struct packed {
    logic fail_out_active_flag;
    logic safe_input_fail_flag;
    logic reset_clamp_flag;
  } fsio_status_s;

  // Fail output controller states
  typedef enum logic [1:0] {
    FSIO_IDLE   = 2'b01,
    FSIO_ACTIVE = 2'b10
  } fsio_state_e;

endpackage

// file: fsio_mcu_model.sv
// Microcontroller model: drives the safe input pin with a square wave.
// Assumes the bench gates it with run; when stopped the port sticks low.
`timescale 1ns/10ps
`default_nettype none

module fsio_mcu_model #(
  parameter int HALF_CYC = 5
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Control from the bench
  input  wire logic run,
  // Pin towards the device
  output logic      safe_input_pin
);
  int cnt;

  always_ff @(posedge clk) begin
    if (!nrst || !run) begin
      cnt <= 0;
      safe_input_pin <= 1'b0;
    end else if (cnt == HALF_CYC - 1) begin
      cnt <= 0;
      safe_input_pin <= !safe_input_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

`default_nettype wire

// file: fsio_testbench.sv
// Self-checking bench for the fail output and safe input block.
// Assumes shortened timing parameters so every waveform fits a short run.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam int BH = 20, DP = 50, DN = 10, WIN = 30;
  logic clk = 1'b0, nrst = 1'b0, wdf = 1'b0, nm = 1'b1, cfg = 1'b0;
  logic sdis = 1'b0, clr_fo = 1'b0, clr_si = 1'b0, run = 1'b1;
  logic sip, s_n, b_n, d_n;
  fsio_pkg::fsio_fail_in_s fin = '0;
  fsio_pkg::fsio_status_s  st;
  int bad_count = 0;
  int n_checks = 0;

  // Device and far side
  fsio_fail_out #(.BLINK_HALF_CYC(BH), .DIM_PERIOD_CYC(DP),
    .DIM_ON_CYC(DN), .WIN_CYC(WIN)) dut (
    .clk(clk), .nrst(nrst), .fail_in(fin), .watchdog_fail_flag(wdf),
    .normal_mode(nm), .watchdog_fail_flag_count_cfg(cfg), .safe_input_disable(sdis),
    .clr_fail_out_active(clr_fo), .clr_safe_input_fail(clr_si),
    .safe_input_pin(sip), .static_fail_out_n(s_n), .blink_fail_out_n(b_n),
    .dim_fail_out_n(d_n), .device_status_reg(st));
  fsio_mcu_model mcu (.clk(clk), .nrst(nrst), .run(run),
    .safe_input_pin(sip));

  // Clock
  always #5 clk = ~clk;

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk) nrst <= 1'b0;
    tick(12);
    @(posedge clk) nrst <= 1'b1;
    #1;
  endtask

  // One-cycle strobe: 0 clear active, 1 clear safe input, 2 watchdog fail
  task automatic pulse(int k);
    @(posedge clk);
    case (k)
      0: clr_fo <= 1'b1;
      1: clr_si <= 1'b1;
      default: fin.watchdog_fail_flag_event <= 1'b1;
    endcase
    @(posedge clk);
    {clr_fo, clr_si, fin.watchdog_fail_flag_event} <= 3'b000;
    tick(3);
  endtask

  task automatic state(string w, logic es, logic [2:0] est);
    check({w, " static"}, s_n, es);
    check({w, " status"}, st, est);
  endtask

  // Low cycles of blink and dimmer over a common multiple of periods
  task automatic wave(int eb, int ed);
    int cb;
    int cd;
    cb = 0;
    cd = 0;
    repeat (200) begin
      tick(1);
      cb += (b_n === 1'b0);
      cd += (d_n === 1'b0);
    end
    check("blink low cycles", cb, eb);
    check("dim low cycles", cd, ed);
  endtask

  initial begin
    do_reset();
    state("reset", 1'b1, 3'b000);
    // Thermal, supply short and reset clamp in turn
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      nm <= (k != 0);
      fin.thermal_shutdown_stage2 <= (k == 0);
      fin.main_supply_rail_short <= (k == 1);
      {fin.reset_out_asserted, fin.reset_out_pin_fb} <= {2{k == 2}};
      tick(3);
      state("fail on", 1'b0, {2'b10, k == 2});
      wave(100, 40);
      pulse(0);
      state("clear refused", 1'b0, {2'b10, k == 2});
      @(posedge clk) fin <= '0;
      pulse(0);
      state("released", 1'b1, 3'b000);
      check("blink off", b_n, 1'b1);
      $display("test source %0d done", k);
    end
    // Reset asserted with the pin reading low is no clamp
    @(posedge clk) fin.reset_out_asserted <= 1'b1;
    tick(3);
    state("clamp needs high", 1'b1, 3'b000);
    @(posedge clk) fin <= '0;
    tick(1);
    $display("test clamp level done");
    // Watchdog trips on the first or the second failure
    for (int c = 0; c < 2; c++) begin
      do_reset();
      @(posedge clk);
      cfg <= c[0];
      wdf <= 1'b1;
      pulse(2);
      state("wd one", c[0], {!c[0], 2'b00});
      pulse(2);
      state("wd two", 1'b0, 3'b100);
      pulse(0);
      check("wd held", s_n, 1'b0);
      @(posedge clk) wdf <= 1'b0;
      pulse(0);
      state("wd released", 1'b1, 3'b000);
      $display("test watchdog %0d done", c);
    end
    // Safe input: edges kept, then missed
    do_reset();
    tick(3 * WIN);
    state("si toggling", 1'b1, 3'b000);
    @(posedge clk) run <= 1'b0;
    tick(2 * WIN + 5);
    state("si miss", 1'b0, 3'b010);
    wave(0, 40);
    pulse(1);
    state("si early clear", 1'b0, 3'b010);
    @(posedge clk) run <= 1'b1;
    tick(12);
    pulse(1);
    state("si cleared", 1'b1, 3'b000);
    $display("test safe input done");
    // Check off when disabled, or outside normal mode
    for (int m = 0; m < 2; m++) begin
      do_reset();
      @(posedge clk);
      sdis <= !m[0];
      nm <= !m[0];
      run <= 1'b0;
      tick(3 * WIN);
      state("si off", 1'b1, 3'b000);
      $display("test safe input off %0d done", m);
    end
    final_report();
  end

  // Hang guard
  initial begin
    #100000;
    bad_count++;
    final_report();
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
endmodule

`default_nettype wire
